//--- logic/dcr_defines.vh
// Constants for the converter settings block and its serial slave
`ifndef DCR_DEFINES_VH
`define DCR_DEFINES_VH
`define DCR_DEV_CODE      4'hc
`define DCR_GC_ADDR       7'h00
`define DCR_GC_RESET      8'h06
`define DCR_GC_WAKE       8'h09
`define DCR_CFG_W         5
`define DCR_LVL_W         12
`define DCR_REF_HI        4
`define DCR_REF_LO        3
`define DCR_SD_HI         2
`define DCR_SD_LO         1
`define DCR_GAIN_BIT      0
`define DCR_CFG_BOR       5'h06
`define DCR_CFG_SHIP      5'h00
`define DCR_LVL_SHIP      12'h000
`define DCR_SD_NORMAL     2'h0
`define DCR_SD_STRONG     2'h1
`define DCR_SD_MEDIUM     2'h2
`define DCR_SD_WEAK       2'h3
`define DCR_CMD_VOL_LVL   2'h0
`define DCR_CMD_VOL_MEM   3'h2
`define DCR_CMD_ALL_MEM   3'h3
`define DCR_CMD_VOL_CFG   3'h4
`define DCR_NV_CFG_IDX    1'h0
`define DCR_NV_LVL_IDX    1'h1
`endif

//--- logic/dcr_nv_store.v
// Small stored-value memory for configuration and level, registered read
`include "dcr_defines.vh"
module dcr_nv_store (
	input  wire        clk_sys,
	input  wire        rstn,
	input  wire        wrEn,
	input  wire [11:0] wrCfgLvl,
	input  wire [4:0]  wrCfg,
	output reg  [4:0]  rdCfg,
	output reg  [11:0] rdLvl
);
	reg [4:0]  memCfg = `DCR_CFG_SHIP;
	reg [11:0] memLvl = `DCR_LVL_SHIP;

	// Cells survive rstn, since rstn stands for power-on; shipped
	// contents come from the initialiser. No writes while in reset.
	always @(posedge clk_sys) begin
		if (wrEn && rstn) begin
			memCfg <= wrCfg;
			memLvl <= wrCfgLvl;
		end
		// Read register tracks the cells through reset too
		rdCfg <= memCfg;
		rdLvl <= memLvl;
	end
endmodule

//--- logic/dcr_config_regs.v
// Converter settings registers behind a two-wire serial slave port
`include "dcr_defines.vh"
module dcr_config_regs #(
	parameter [2:0] ADDR_PINS = 3'h0,
	parameter       LVL_BITS  = 12
) (
	input  wire        clk_sys,
	input  wire        rstn,
	input  wire        brownoutEvent,
	input  wire        sclIn,
	input  wire        sdaIn,
	output reg         sdaOut,
	output reg         sdaOe,
	output reg  [1:0]  ladderRefSelect,
	output reg         refBuffered,
	output reg  [1:0]  shutdownLoadSelect,
	output reg         poweredDown,
	output reg         outAmpConnected,
	output reg         gainDouble,
	output reg  [11:0] outputLevel,
	output reg         eeBusyFlag
);
	// Bus states, one-hot
	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_ADDR = 6'h02;
	localparam [5:0] ST_AACK = 6'h04;
	localparam [5:0] ST_WR   = 6'h08;
	localparam [5:0] ST_WACK = 6'h10;
	localparam [5:0] ST_RD   = 6'h20;

	// Mask of implemented level bits for this variant
	localparam [11:0] LVL_MASK = 12'hfff << (12 - LVL_BITS);

	reg [2:0]  sclSync;
	reg [2:0]  sdaSync;
	reg [5:0]  state;
	reg [3:0]  bitCnt;
	reg [7:0]  shift;
	reg        isRead;
	reg        isGc;
	reg [2:0]  byteIdx;
	reg [7:0]  b0;
	reg [7:0]  b1;
	reg [4:0]  cfg;
	reg        nvWr;
	reg [4:0]  nvCfgIn;
	reg [11:0] nvLvlIn;
	reg        recall;
	reg        bor;
	reg        borSync1;
	reg        borSeen;
	reg [7:0]  rdByte;
	wire [4:0]  nvCfg;
	wire [11:0] nvLvl;

	wire sclRise = sclSync[1] & ~sclSync[2];
	wire sclFall = ~sclSync[1] & sclSync[2];
	wire startCond = sclSync[1] & sclSync[2] & sdaSync[2] & ~sdaSync[1];
	wire stopCond  = sclSync[1] & sclSync[2] & ~sdaSync[2] & sdaSync[1];

	// Clear the unimplemented low bits of a 12-bit code as written on the bus for the variant
	function [11:0] fitLevel;
		input [11:0] raw;
		begin
			fitLevel = raw & LVL_MASK;
		end
	endfunction

	dcr_nv_store uStore (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.wrEn     (nvWr),
		.wrCfgLvl (nvLvlIn),
		.wrCfg    (nvCfgIn),
		.rdCfg    (nvCfg),
		.rdLvl    (nvLvl)
	);

	// Two-stage synchronisers; third stage for edge finding, and data bits are also sampled from it.
	// Oversampling leaves many samples per half-bit at all rates
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sclSync  <= 3'h7;
			sdaSync  <= 3'h7;
			borSync1 <= 1'b0;
			bor      <= 1'b0;
		end else begin
			sclSync  <= {sclSync[1:0], sclIn};
			sdaSync  <= {sdaSync[1:0], sdaIn};
			borSync1 <= brownoutEvent;
			bor      <= borSync1;
		end
	end

	// Serial slave state machine; clock line is never driven
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state   <= ST_IDLE;
			bitCnt  <= 4'h0;
			shift   <= 8'h00;
			isRead  <= 1'b0;
			isGc    <= 1'b0;
			byteIdx <= 3'h0;
			b0      <= 8'h00;
			b1      <= 8'h00;
			sdaOut  <= 1'b0;
			sdaOe   <= 1'b0;
			nvWr    <= 1'b0;
			nvCfgIn <= `DCR_CFG_SHIP;
			nvLvlIn <= `DCR_LVL_SHIP;
			recall  <= 1'b1;
			cfg     <= `DCR_CFG_SHIP;
			outputLevel <= `DCR_LVL_SHIP;
			eeBusyFlag  <= 1'b0;
			borSeen <= 1'b0;
			rdByte  <= 8'h00;
		end else begin
			nvWr   <= 1'b0;
			recall <= 1'b0;
			// Store read lags one cycle, so recall acts on the next edge
			if (recall) begin
				cfg         <= nvCfg;
				outputLevel <= fitLevel(nvLvl);
			end
			if (bor) begin
				// Brown-out wins and blocks the port while present
				cfg         <= `DCR_CFG_BOR;
				outputLevel <= `DCR_LVL_SHIP;
				state       <= ST_IDLE;
				sdaOe       <= 1'b0;
				borSeen     <= 1'b1;
			end else if (borSeen) begin
				borSeen <= 1'b0;
			end else if (startCond) begin
				state  <= ST_ADDR;
				bitCnt <= 4'h0;
				sdaOe  <= 1'b0;
			end else if (stopCond) begin
				state <= ST_IDLE;
				sdaOe <= 1'b0;
			end else begin
				case (state)
				ST_IDLE: begin
					sdaOe <= 1'b0;
				end
				ST_ADDR: begin
					if (sclRise) begin
						shift  <= {shift[6:0], sdaSync[2]};
						bitCnt <= bitCnt + 4'h1;
					end else if (sclFall && bitCnt == 4'h8) begin
						// Address byte decides ack or release
						if (shift[7:1] == {`DCR_DEV_CODE, ADDR_PINS}) begin
							isRead <= shift[0];
							isGc   <= 1'b0;
							sdaOe  <= 1'b1;
							state  <= ST_AACK;
						end else if (shift[7:1] == `DCR_GC_ADDR
								&& !shift[0]) begin
							// Stale read flag would turn this into a read
							isRead <= 1'b0;
							isGc  <= 1'b1;
							sdaOe <= 1'b1;
							state <= ST_AACK;
						end else begin
							state <= ST_IDLE;
						end
						sdaOut  <= 1'b0;
						bitCnt  <= 4'h0;
						byteIdx <= 3'h0;
					end
				end
				ST_AACK, ST_WACK: begin
					if (sclFall) begin
						bitCnt <= 4'h0;
						if (isRead) begin
							// Read data ready at once; no stretch
							state  <= ST_RD;
							rdByte <= byteIdx == 3'h0
								? {eeBusyFlag, 3'h0, cfg[4:1]}
								: byteIdx == 3'h1
								? outputLevel[11:4]
								: {outputLevel[3:0], 4'h0};
							sdaOe  <= 1'b1;
							sdaOut <= byteIdx == 3'h0 ? eeBusyFlag
								: byteIdx == 3'h1 ? outputLevel[11]
								: outputLevel[3];
						end else begin
							state <= ST_WR;
							sdaOe <= 1'b0;
						end
					end
				end
				ST_WR: begin
					if (sclRise) begin
						shift  <= {shift[6:0], sdaSync[2]};
						bitCnt <= bitCnt + 4'h1;
					end else if (sclFall && bitCnt == 4'h8) begin
						bitCnt  <= 4'h0;
						sdaOut  <= 1'b0;
						sdaOe   <= 1'b1;
						state   <= ST_WACK;
						byteIdx <= byteIdx + 3'h1;
						if (isGc) begin
							if (shift == `DCR_GC_RESET) begin
								recall <= 1'b1;
							end else if (shift == `DCR_GC_WAKE) begin
								cfg[`DCR_SD_HI:`DCR_SD_LO]
									<= `DCR_SD_NORMAL;
							end
						end else if (byteIdx == 3'h0) begin
							b0 <= shift;
							if (shift[7:6] == `DCR_CMD_VOL_LVL) begin
								cfg[`DCR_SD_HI:`DCR_SD_LO]
									<= shift[5:4];
							end else if (shift[7:5]
									== `DCR_CMD_VOL_CFG) begin
								cfg <= shift[4:0];
							end
						end else if (byteIdx == 3'h1) begin
							b1 <= shift;
							if (b0[7:6] == `DCR_CMD_VOL_LVL) begin
								outputLevel <= fitLevel(
									{b0[3:0], shift});
							end
						end else if (byteIdx == 3'h2) begin
							if (b0[7:5] == `DCR_CMD_VOL_MEM
								|| b0[7:5] == `DCR_CMD_ALL_MEM) begin
								cfg <= b0[4:0];
								outputLevel <= fitLevel(
									{b1, shift[7:4]});
							end
							if (b0[7:5] == `DCR_CMD_ALL_MEM) begin
								nvWr    <= 1'b1;
								nvCfgIn <= b0[4:0];
								nvLvlIn <= fitLevel({b1, shift[7:4]});
							end
						end
					end else if (sclFall && bitCnt != 4'h0) begin
						sdaOe <= 1'b0;
					end
				end
				ST_RD: begin
					if (sclFall) begin
						if (bitCnt == 4'h7) begin
							sdaOe  <= 1'b0;
							bitCnt <= 4'h8;
						end else if (bitCnt == 4'h8) begin
							state <= ST_IDLE;
						end else begin
							rdByte <= {rdByte[6:0], 1'b0};
							sdaOut <= rdByte[6];
							bitCnt <= bitCnt + 4'h1;
						end
					end else if (sclRise && bitCnt == 4'h8) begin
						// Master ack continues, nack ends the read
						if (!sdaSync[2]) begin
							state   <= ST_AACK;
							byteIdx <= byteIdx + 3'h1;
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
				endcase
			end
		end
	end

	// Analog control decode from the volatile configuration
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ladderRefSelect    <= 2'h0;
			refBuffered        <= 1'b0;
			shutdownLoadSelect <= 2'h0;
			poweredDown        <= 1'b0;
			outAmpConnected    <= 1'b1;
			gainDouble         <= 1'b0;
		end else begin
			ladderRefSelect <= cfg[`DCR_REF_HI:`DCR_REF_LO];
			refBuffered     <= cfg[`DCR_REF_HI] & cfg[`DCR_REF_LO];
			shutdownLoadSelect <= cfg[`DCR_SD_HI:`DCR_SD_LO];
			poweredDown <= cfg[`DCR_SD_HI:`DCR_SD_LO] != `DCR_SD_NORMAL;
			outAmpConnected <= cfg[`DCR_SD_HI:`DCR_SD_LO]
				== `DCR_SD_NORMAL;
			// Supply rail reference cannot use double gain
			gainDouble <= cfg[`DCR_GAIN_BIT] & cfg[`DCR_REF_HI];
		end
	end
endmodule

//--- dv/dcr_config_regs_sva.sv
// Property checker for the converter settings block
module dcr_config_regs_sva (
	input wire logic        clk_sys,
	input wire logic        rstn,
	input wire logic        brownoutEvent,
	input wire logic        sclIn,
	input wire logic        sdaOe,
	input wire logic [1:0]  ladderRefSelect,
	input wire logic        refBuffered,
	input wire logic [1:0]  shutdownLoadSelect,
	input wire logic        poweredDown,
	input wire logic        outAmpConnected,
	input wire logic        gainDouble,
	input wire logic [11:0] outputLevel
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// Decoded analog controls must track the stored fields
	chk_ref_buffered: assert property (refBuffered == (ladderRefSelect == 2'h3))
		else $error("buffer flag wrong");
	chk_pd_flag: assert property (poweredDown == (shutdownLoadSelect != 2'h0))
		else $error("power-down flag wrong");
	chk_amp_detach: assert property (poweredDown |-> !outAmpConnected)
		else $error("amplifier left connected");
	chk_gain_pin: assert property (gainDouble |-> ladderRefSelect == 2'h3 || ladderRefSelect == 2'h2)
		else $error("double gain without pin");
	chk_unity_gain: assert property (!ladderRefSelect[1] |-> !gainDouble)
		else $error("gain not forced to unity");
	// Sync delay is two stages plus the settings register, plus the decode register for the analog controls
	chk_bor_cfg: assert property (brownoutEvent[*4] |=> ladderRefSelect == 2'h0 && shutdownLoadSelect == 2'h3 && !gainDouble)
		else $error("brown-out settings wrong");
	chk_bor_level: assert property (brownoutEvent[*4] |=> outputLevel == 12'h000)
		else $error("brown-out level wrong");
	// Slave turns its driver on and off only while clock is low
	chk_oe_clk_low: assert property ($rose(sdaOe) || $fell(sdaOe) |-> !sclIn)
		else $error("data driver moved with clock high");
	cover property ($rose(sdaOe));
	cover property (poweredDown && gainDouble);
	cover property (brownoutEvent[*4]);
endmodule

//--- dv/dcr_i2c_master.sv
// Serial bus master model: makes the clock, pulls data low only
module dcr_i2c_master (
	output logic sclOut,
	output logic sdaLow,
	input  wire  sdaIn
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle bus: clock high, data released to the pull-up
	initial begin
		sclOut = 1'b1;
		sdaLow = 1'b0;
	end
	// Data falls while clock high
	task start();
		sdaLow = 1'b1;
		#16 sclOut = 1'b0;
		#8;
	endtask
	// Data moves only while clock is low
	task bitOut(input logic b);
		sdaLow = !b;
		#8 sclOut = 1'b1;
		#16 sclOut = 1'b0;
		#8;
	endtask
	task bitIn(output logic b);
		sdaLow = 1'b0;
		#8 sclOut = 1'b1;
		#8 b = sdaIn;
		#8 sclOut = 1'b0;
		#8;
	endtask
	// Data rises while clock high
	task stop();
		sdaLow = 1'b1;
		#8 sclOut = 1'b1;
		#8 sdaLow = 1'b0;
		#16;
	endtask
	task sendByte(input logic [7:0] d, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) bitOut(d[i]);
		bitIn(a);
		ack = !a;
	endtask
	task recvByte(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) bitIn(d[i]);
		bitOut(last);
	endtask
endmodule

//--- dv/dac_config_regs_i2c_slave_bench.sv
// Self-checking bench for the converter settings block
module dac_config_regs_i2c_slave_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clkSys = 1'b0;
	logic        rstn = 1'b0;
	logic        brownoutEvent = 1'b0;
	logic        ack;
	logic [7:0]  rd;
	logic [4:0]  tbl [4] = '{5'h1b, 5'h15, 5'h0f, 5'h01};
	wire         sclIn, sdaLow, sdaWire, sdaOut, sdaOe, refBuffered;
	wire         poweredDown, outAmpConnected, gainDouble, eeBusyFlag;
	wire  [1:0]  ladderRefSelect, shutdownLoadSelect;
	wire  [11:0] outputLevel;
	int          failures = 0;
	int          check_count = 0;
	int          cycles = 0;
	// Open-drain wire with pull-up
	assign sdaWire = !(sdaLow || (sdaOe && !sdaOut));
	always #2 clkSys = ~clkSys;
	// Hang guard
	always @(posedge clkSys) begin
		cycles++;
		if (cycles == 30000) begin
			failures++;
			conclude();
		end
	end
	dcr_config_regs dcr_config_regs_i (.clk_sys(clkSys), .rstn(rstn),
		.brownoutEvent(brownoutEvent), .sclIn(sclIn), .sdaIn(sdaWire),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .ladderRefSelect(ladderRefSelect),
		.refBuffered(refBuffered), .shutdownLoadSelect(shutdownLoadSelect),
		.poweredDown(poweredDown), .outAmpConnected(outAmpConnected),
		.gainDouble(gainDouble), .outputLevel(outputLevel),
		.eeBusyFlag(eeBusyFlag));
	dcr_i2c_master dcr_i2c_master_i (.sclOut(sclIn), .sdaLow(sdaLow),
		.sdaIn(sdaWire));
	task check(input string name, input logic [11:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task conclude();
		if (failures == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task settle();
		repeat (12) @(posedge clkSys);
		#1;
	endtask
	// Address byte first, then command bytes, each ack compared with ackExp; stops at the first nack
	task send(input int n, input logic [31:0] w, input logic ackExp);
		dcr_i2c_master_i.start();
		for (int i = 0; i < n; i++) begin
			dcr_i2c_master_i.sendByte(w[31-8*i -: 8], ack);
			check("ack", {11'h0, ack}, {11'h0, ackExp});
			if (!ack) break;
		end
		dcr_i2c_master_i.stop();
		settle();
	endtask
	task cfgIs(input logic [4:0] c);
		check("cfg", {3'h0, ladderRefSelect, refBuffered, shutdownLoadSelect,
			poweredDown, outAmpConnected, gainDouble}, {3'h0, c[4:3], &c[4:3],
			c[2:1], |c[2:1], ~|c[2:1], c[0] & c[4]});
	endtask
	// Main sequence
	initial begin
		repeat (8) @(posedge clkSys);
		#1 rstn = 1'b1;
		settle();
		cfgIs(5'h00);
		check("level", outputLevel, 12'h000);
		for (int i = 0; i < 4; i++) begin
			send(2, {8'hc0, 3'h4, tbl[i], 16'h0}, 1'b1);
			cfgIs(tbl[i]);
		end
		send(3, {8'hc0, 8'h0a, 8'hbc, 8'h00}, 1'b1);
		check("level", outputLevel, 12'habc);
		// Read back with no clock stretching available to the slave
		dcr_i2c_master_i.start();
		dcr_i2c_master_i.sendByte(8'hc1, ack);
		check("ack", {11'h0, ack}, 12'h001);
		for (int i = 0; i < 3; i++) begin
			dcr_i2c_master_i.recvByte(i == 2, rd);
			check("read", {4'h0, rd},
				{4'h0, 8'(24'h00abc0 >> (16 - 8*i))});
		end
		dcr_i2c_master_i.stop();
		settle();
		send(4, {8'hc0, 8'h75, 8'h5a, 8'h30}, 1'b1);
		send(2, {8'hc0, 8'h8f, 16'h0}, 1'b1);
		cfgIs(5'h0f);
		send(2, {8'h00, 8'h06, 16'h0}, 1'b1);
		cfgIs(5'h15);
		check("level", outputLevel, 12'h5a3);
		send(2, {8'hc2, 8'h80, 16'h0}, 1'b0);
		cfgIs(5'h15);
		send(4, {8'hc0, 8'h58, 8'h12, 8'h30}, 1'b1);
		cfgIs(5'h18);
		check("level", outputLevel, 12'h123);
		// Power cycle: volatile write lost, stored settings come back
		rstn = 1'b0;
		repeat (3) @(posedge clkSys);
		#1 rstn = 1'b1;
		settle();
		cfgIs(5'h15);
		check("level", outputLevel, 12'h5a3);
		brownoutEvent = 1'b1;
		settle();
		cfgIs(5'h06);
		check("level", outputLevel, 12'h000);
		brownoutEvent = 1'b0;
		settle();
		// General call wake clears only the shutdown field
		send(2, {8'h00, 8'h09, 16'h0}, 1'b1);
		cfgIs(5'h00);
		conclude();
	end
endmodule
bind dcr_config_regs dcr_config_regs_sva dcr_config_regs_sva_i (
	.clk_sys(clk_sys), .rstn(rstn), .brownoutEvent(brownoutEvent),
	.sclIn(sclIn), .sdaOe(sdaOe), .ladderRefSelect(ladderRefSelect),
	.refBuffered(refBuffered), .shutdownLoadSelect(shutdownLoadSelect),
	.poweredDown(poweredDown), .outAmpConnected(outAmpConnected),
	.gainDouble(gainDouble), .outputLevel(outputLevel));
